/* File: hdl/cc_adv_decode.sv */
// decode of the three-level current-advertisement input into a pull-up choice
`timescale 1ns/1ps
module cc_adv_decode
(
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // synchronised level comparator outputs
    input  wire logic                adv_above_low,
    input  wire logic                adv_above_mid,
    input  wire logic                enable,
    output cc_src_pkg::pullup_t      pullup_sel
);
    import cc_src_pkg::*;

    // registered so the pull-up never glitches between comparator edges
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pullup_sel <= '{enable: 1'b0, level: ADV_DEFAULT, current_ua: PULLUP_UA_DEFAULT};
        else
        begin
            pullup_sel.enable <= enable;
            if (adv_above_mid)
            begin
                pullup_sel.level      <= ADV_HIGH;
                pullup_sel.current_ua <= PULLUP_UA_HIGH;
            end
            else if (adv_above_low)
            begin
                pullup_sel.level      <= ADV_MEDIUM;
                pullup_sel.current_ua <= PULLUP_UA_MEDIUM;
            end
            else
            begin
                pullup_sel.level      <= ADV_DEFAULT;
                pullup_sel.current_ua <= PULLUP_UA_DEFAULT;
            end
        end
    end

endmodule

/* File: hdl/cc_src_ctrl.sv */
// top of the type-c source-only cc controller with apb registers
// Summary of operation
// [R01] a sink on the cc wires must persist for the 168 ms debounce before the port counts as attached.
// [R02] the vbus sense input is debounced for 2 ms before its new level is acted upon.
// [R03] as a source only, pull-ups are applied to both cc wires with strength set by the advertisement input.
// [R04] a low advertisement input advertises default usb current (500 mA or 900 mA).
// [R05] a mid input advertises 1.5 A and a high input advertises 3 A.
// [R06] with vbus sensed low and a sink seen on either wire, vbus is safe and the attach indicator goes low.
// [R07] with the vbus sense left open the system must itself make sure vbus is at safe zero first.
// [R08] the open-drain orientation output is driven low for cc1 and released high for cc2.
// [R09] two modes exist: unattached (unattached and attach-wait states) and active (attached state).
// [R10] after reset the controller is unattached and watches the cc wires until an attach is confirmed.
// [R11] in active mode attachment is shown on the attach indicator, and removal leaves active mode.
// [R12] all inputs and outputs stay working while unattached.
// [R13] the system provides its own vbus discharge since none is done here.
// [R14] pull-up current is 80, 180 or 330 microamperes for default, medium and high.
// [R15] on detach the state returns to unattached, the indicator is released and monitoring restarts.
// [R16] the advertisement input is decoded into three levels applied to both cc wires together.
`timescale 1ns/1ps
module cc_src_ctrl
    import cc_src_pkg::*;
#(
    parameter int           ATTACH_CYCLES = ATTACH_DEBOUNCE_CYCLES,
    parameter int           VBUS_CYCLES   = VBUS_DEBOUNCE_CYCLES
)
(
    // apb clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // cc wire sink detection from the comparators
    input  wire logic              cc1_sink_seen,
    input  wire logic              cc2_sink_seen,
    // advertisement input comparators
    input  wire logic              adv_above_low,
    input  wire logic              adv_above_mid,
    // vbus sense comparator, high above vbus_valid_threshold
    input  wire logic              vbus_sense_in,
    // pull-up drive to both cc wires
    output cc_src_pkg::pullup_t    cc_pullup,
    // open-drain attach indicator and orientation
    output logic                   attach_indicator_n_o,
    output logic                   attach_indicator_n_oe,
    output logic                   orient_o,
    output logic                   orient_oe,
    // mode and interrupt
    output logic                   active_mode,
    output logic                   irq
);

    initial
    begin
        if (ATTACH_CYCLES < 2 || VBUS_CYCLES < 1)
            $error("cc_src_ctrl: debounce counts too small");
    end

    cc_state_t  state;
    cc_pair_t   sink_stable;
    logic       vbus_stable;
    logic       vbus_stable_d;
    logic       enable;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [3:0] events;
    logic [1:0] adv_sync;
    adv_level_t adv_prev;
    logic       wr_en;
    logic       rd_en;
    logic       addr_ok;

    // cc detection with two-flop sync, no debounce beyond the attach window
    cc_sync_filter #(.WIDTH(2), .CYCLES(1)) u_cc_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     ({cc1_sink_seen, cc2_sink_seen}),
        .synced  (),
        .stable  (sink_stable)
    );

    // vbus sense synced and debounced
    cc_sync_filter #(.WIDTH(1), .CYCLES(VBUS_CYCLES)) u_vbus_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     (vbus_sense_in),
        .synced  (),
        .stable  (vbus_stable)  // [R02]
    );

    // advertisement comparators synced before decode
    cc_sync_filter #(.WIDTH(2), .CYCLES(1)) u_adv_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     ({adv_above_mid, adv_above_low}),
        .synced  (adv_sync),
        .stable  ()
    );

    // one pull-up choice drives both wires
    cc_adv_decode u_adv
    (
        .pclk          (pclk),
        .presetn       (presetn),
        .adv_above_low (adv_sync[0]),  // [R04] [R05] [R16]
        .adv_above_mid (adv_sync[1]),  // [R14]
        .enable        (enable),       // [R03]
        .pullup_sel    (cc_pullup)
    );

    logic                    sink_any;
    logic [$clog2(ATTACH_CYCLES+1)-1:0] attach_count;
    localparam int ACW = $clog2(ATTACH_CYCLES + 1);

    assign sink_any = sink_stable.cc1 | sink_stable.cc2;

    // connection state machine
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state        <= ST_UNATTACHED;  // [R10]
            attach_count <= '0;
        end
        else if (!enable)
        begin
            state        <= ST_UNATTACHED;
            attach_count <= '0;
        end
        else
        begin
            unique case (state)
                ST_UNATTACHED:
                begin
                    attach_count <= '0;
                    if (sink_any)
                        state <= ST_ATTACH_WAIT;  // [R09]
                end
                ST_ATTACH_WAIT:
                begin
                    // sink must hold for the full window with vbus safe
                    if (!sink_any)
                    begin
                        state        <= ST_UNATTACHED;
                        attach_count <= '0;
                    end
                    else if (attach_count == ACW'(ATTACH_CYCLES - 2))
                    begin
                        if (!vbus_stable)
                            state <= ST_ATTACHED;  // [R01] [R06]
                    end
                    else
                        attach_count <= attach_count + ACW'(1);
                end
                ST_ATTACHED:
                begin
                    attach_count <= '0;
                    if (!sink_any)
                        state <= ST_UNATTACHED;  // [R11] [R15]
                end
            endcase
        end
    end

    // open-drain outputs, registered from state and from the cc sink detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            attach_indicator_n_o  <= 1'b0;
            attach_indicator_n_oe <= 1'b0;
            orient_o              <= 1'b0;
            orient_oe             <= 1'b0;
            active_mode           <= 1'b0;
        end
        else
        begin
            attach_indicator_n_o  <= 1'b0;
            attach_indicator_n_oe <= (state == ST_ATTACHED);  // [R06] [R11] [R15]
            orient_o              <= 1'b0;
            // cc1 pulls low, cc2 releases to the external pull-up
            if (sink_stable.cc1)
                orient_oe <= 1'b1;  // [R08] [R12]
            else if (sink_stable.cc2)
                orient_oe <= 1'b0;  // [R08]
            active_mode           <= (state == ST_ATTACHED);  // [R09]
        end
    end

    // event detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vbus_stable_d <= 1'b0;
            adv_prev      <= ADV_DEFAULT;
        end
        else
        begin
            vbus_stable_d <= vbus_stable;
            adv_prev      <= cc_pullup.level;
        end
    end

    assign events[EV_ATTACH] = (state == ST_ATTACH_WAIT) && sink_any && !vbus_stable
                               && enable && (attach_count == ACW'(ATTACH_CYCLES - 2));
    assign events[EV_DETACH] = (state == ST_ATTACHED) && !sink_any && enable;
    assign events[EV_VBUS]   = vbus_stable ^ vbus_stable_d;
    assign events[EV_ADV]    = cc_pullup.level != adv_prev;

    // apb decode: zero wait states
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign addr_ok = (paddr == CTRL_OFFSET) || (paddr == STATUS_OFFSET)
                     || (paddr == IRQ_OFFSET) || (paddr == MASK_OFFSET);

    // control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            enable <= CTRL_RESET_VALUE[CTRL_ENABLE_BIT];
        else if (wr_en && paddr == CTRL_OFFSET && pstrb[0])
            enable <= pwdata[CTRL_ENABLE_BIT];
    end

    // sticky status, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status <= IRQ_RESET_VALUE;
        else if (wr_en && paddr == IRQ_OFFSET && pstrb[0])
            irq_status <= (irq_status & ~pwdata[3:0]) | events;
        else
            irq_status <= irq_status | events;
    end

    // mask register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask <= MASK_RESET_VALUE;
        else if (wr_en && paddr == MASK_OFFSET && pstrb[0])
            irq_mask <= pwdata[3:0];
    end

    // interrupt level from unmasked status
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_mask);
    end

    // read data captured in setup so it is valid during access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (rd_en)
            begin
                unique case (paddr)
                    CTRL_OFFSET:   prdata <= {31'h0, enable};
                    STATUS_OFFSET: prdata <= {24'h0, 2'h0, cc_pullup.level, vbus_stable,
                                              sink_stable.cc2, sink_stable.cc1, state == ST_ATTACHED};
                    IRQ_OFFSET:    prdata <= {28'h0, irq_status};
                    MASK_OFFSET:   prdata <= {28'h0, irq_mask};
                    default:       prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // assertions
    chk_attach_needs_wait: assert property (@(posedge pclk) disable iff (!presetn)  // [R01]
        (state == ST_UNATTACHED) ##1 (state != ST_UNATTACHED) |-> state == ST_ATTACH_WAIT)
        else $error("attach skipped the wait state");
    chk_attach_window: assert property (@(posedge pclk) disable iff (!presetn)  // [R01]
        $rose(state == ST_ATTACHED) |-> $past(attach_count) == ACW'(ATTACH_CYCLES - 2))
        else $error("attached before the debounce window ran out");
    chk_indicator_follows: assert property (@(posedge pclk) disable iff (!presetn)  // [R06]
        $rose(state == ST_ATTACHED) |=> attach_indicator_n_oe && !attach_indicator_n_o)
        else $error("indicator not driven low on attach");
    chk_detach_release: assert property (@(posedge pclk) disable iff (!presetn)  // [R15]
        (state == ST_ATTACHED && !sink_any && enable) |=> state == ST_UNATTACHED ##1
        !attach_indicator_n_oe)
        else $error("detach did not release indicator");
    chk_orient_cc1: assert property (@(posedge pclk) disable iff (!presetn)  // [R08]
        sink_stable.cc1 |=> orient_oe && !orient_o)
        else $error("orientation not low for cc1");
    chk_orient_cc2: assert property (@(posedge pclk) disable iff (!presetn)  // [R08]
        (sink_stable.cc2 && !sink_stable.cc1) |=> !orient_oe)
        else $error("orientation not released for cc2");
    chk_vbus_blocks: assert property (@(posedge pclk) disable iff (!presetn)  // [R06]
        (state == ST_ATTACH_WAIT && vbus_stable) |=> state != ST_ATTACHED)
        else $error("attached with vbus present");
    chk_mode_mirror: assert property (@(posedge pclk) disable iff (!presetn)  // [R09]
        ##1 active_mode == $past(state == ST_ATTACHED))
        else $error("mode output disagrees with state");
    chk_pullup_current: assert property (@(posedge pclk) disable iff (!presetn)  // [R14]
        cc_pullup.level == ADV_HIGH |-> cc_pullup.current_ua == PULLUP_UA_HIGH)
        else $error("high advertisement with wrong current");
    chk_adv_default: assert property (@(posedge pclk) disable iff (!presetn)  // [R04] [R14]
        (adv_sync == 2'b00) |=> cc_pullup.level == ADV_DEFAULT
        && cc_pullup.current_ua == PULLUP_UA_DEFAULT)
        else $error("open or low advertisement not decoded as default");
    chk_adv_medium: assert property (@(posedge pclk) disable iff (!presetn)  // [R05] [R14]
        (adv_sync == 2'b01) |=> cc_pullup.level == ADV_MEDIUM
        && cc_pullup.current_ua == PULLUP_UA_MEDIUM)
        else $error("mid advertisement not decoded as medium");
    chk_adv_high: assert property (@(posedge pclk) disable iff (!presetn)  // [R05] [R16]
        adv_sync[1] |=> cc_pullup.level == ADV_HIGH)
        else $error("high advertisement not decoded");
    chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        |(irq_status & irq_mask) |=> irq)
        else $error("interrupt not raised");

    cov_attach: cover property (@(posedge pclk) disable iff (!presetn) $rose(active_mode));
    cov_detach: cover property (@(posedge pclk) disable iff (!presetn) $fell(active_mode));
    cov_abort:  cover property (@(posedge pclk) disable iff (!presetn)
        state == ST_ATTACH_WAIT ##1 state == ST_UNATTACHED);
    cov_high:   cover property (@(posedge pclk) disable iff (!presetn) cc_pullup.level == ADV_HIGH);

endmodule

/* File: hdl/cc_src_pkg.sv */
// constants, types and register map of the type-c source cc controller
package cc_src_pkg;

    // clock and timing
    localparam int          CLK_MHZ                 = 250;
    localparam int          ATTACH_DEBOUNCE_TIME_MS = 168;
    localparam int          VBUS_DEBOUNCE_TIME_MS   = 2;
    localparam int          ATTACH_DEBOUNCE_CYCLES  = ATTACH_DEBOUNCE_TIME_MS * 1000 * CLK_MHZ;
    localparam int          VBUS_DEBOUNCE_CYCLES    = VBUS_DEBOUNCE_TIME_MS * 1000 * CLK_MHZ;

    // pull-up source currents in microamperes
    localparam logic [8:0]  PULLUP_UA_DEFAULT = 9'd80;
    localparam logic [8:0]  PULLUP_UA_MEDIUM  = 9'd180;
    localparam logic [8:0]  PULLUP_UA_HIGH    = 9'd330;

    // register byte offsets
    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] IRQ_OFFSET    = 12'h008;
    localparam logic [11:0] MASK_OFFSET   = 12'h00c;

    // ctrl fields
    localparam int          CTRL_ENABLE_BIT   = 0;
    localparam logic [31:0] CTRL_RESET_VALUE  = 32'h0000_0001;
    localparam logic [3:0]  IRQ_RESET_VALUE   = 4'h0;
    localparam logic [3:0]  MASK_RESET_VALUE  = 4'h0;

    // interrupt event bit positions
    localparam int          EV_ATTACH = 0;
    localparam int          EV_DETACH = 1;
    localparam int          EV_VBUS   = 2;
    localparam int          EV_ADV    = 3;

    // three-valued current advertisement
    typedef enum logic [1:0]
    {
        ADV_DEFAULT,
        ADV_MEDIUM,
        ADV_HIGH
    } adv_level_t;

    // connection states
    typedef enum logic [1:0]
    {
        ST_UNATTACHED,
        ST_ATTACH_WAIT,
        ST_ATTACHED
    } cc_state_t;

    // sink-pull-down detection on the two cc wires
    typedef struct packed
    {
        logic cc1;
        logic cc2;
    } cc_pair_t;

    // pull-up drive applied to the cc wires
    typedef struct packed
    {
        logic       enable;
        adv_level_t level;
        logic [8:0] current_ua;
    } pullup_t;

endpackage

/* File: hdl/cc_sync_filter.sv */
// two-flop synchroniser followed by a stability debounce counter
`timescale 1ns/1ps
module cc_sync_filter
#(
    parameter int           WIDTH  = 1,
    parameter int           CYCLES = 500
)
(
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // raw asynchronous input and results
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] synced,
    output logic      [WIDTH-1:0] stable
);

    localparam int CW = $clog2(CYCLES + 1);

    initial
    begin
        if (CYCLES < 1 || WIDTH < 1)
            $error("cc_sync_filter: CYCLES and WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] meta;
    logic [CW-1:0]    count;

    // first flop is read only by the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta   <= '0;
            synced <= '0;
        end
        else
        begin
            meta   <= raw;
            synced <= meta;
        end
    end

    // a return to the stable value restarts the stability window; a change to another new value does not
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count  <= '0;
            stable <= '0;
        end
        else if (synced == stable)
            count <= '0;
        else if (count == CW'(CYCLES - 1))
        begin
            count  <= '0;
            stable <= synced;
        end
        else
            count <= count + CW'(1);
    end

endmodule

/* File: verification/cc_sink_model.sv */
// sink-side partner that presents rd on one cc wire of the port
`timescale 1ns/1ps
module cc_sink_model
(
    // clock
    input  wire logic       pclk,
    // plug control from the bench
    input  wire logic       plugged,
    input  wire logic       flipped,
    input  wire logic [7:0] settle,
    // rd seen by the source comparators
    output logic            cc1_sink_seen,
    output logic            cc2_sink_seen
);
    logic [7:0] settle_cnt = 8'h00;

    // a slow plug shows rd only after the settle count; an unplug is seen at once
    always @(posedge pclk)
    begin
        if (!plugged)
            settle_cnt <= 8'h00;
        else if (settle_cnt != settle)
            settle_cnt <= settle_cnt + 8'h01;
    end

    // rd sits on one wire only, chosen by plug orientation
    assign cc1_sink_seen = plugged && (settle_cnt == settle) && !flipped;
    assign cc2_sink_seen = plugged && (settle_cnt == settle) && flipped;
endmodule

/* File: verification/test_cc_src_ctrl.sv */
// self-checking bench of the source cc controller with a sink partner
`timescale 1ns/1ps
module test_cc_src_ctrl;
    import cc_src_pkg::*;
    localparam int ATT = 20;
    localparam int VB  = 5;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        cc1, cc2, adv_low, adv_mid, vbus, plugged, flipped;
    logic [7:0]  settle;
    pullup_t     cc_pullup;
    logic        ind_o, ind_oe, orient_o, orient_oe, active_mode, irq;
    int          num_errors = 0;
    int          checks = 0;
    wire logic [3:0] obs = {active_mode, ind_oe, orient_oe, irq};
    // rows: {above_low, above_mid} beside expected level and pull-up microamps
    logic [1:0]  row_in [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
    adv_level_t  row_lvl [4] = '{ADV_MEDIUM, ADV_HIGH, ADV_HIGH, ADV_DEFAULT};
    logic [8:0]  row_ua [4] = '{9'h0b4, 9'h14a, 9'h14a, 9'h050};

    // short debounce counts keep the run brief
    cc_src_ctrl #(.ATTACH_CYCLES(ATT), .VBUS_CYCLES(VB)) cc_src_ctrl_i
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cc1_sink_seen(cc1), .cc2_sink_seen(cc2), .adv_above_low(adv_low),
        .adv_above_mid(adv_mid), .vbus_sense_in(vbus), .cc_pullup(cc_pullup),
        .attach_indicator_n_o(ind_o), .attach_indicator_n_oe(ind_oe),
        .orient_o(orient_o), .orient_oe(orient_oe), .active_mode(active_mode), .irq(irq)
    );

    cc_sink_model cc_sink_model_i
    (
        .pclk(pclk), .plugged(plugged), .flipped(flipped), .settle(settle),
        .cc1_sink_seen(cc1), .cc2_sink_seen(cc2)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer; waits for pready, takes data at that edge only
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50)
            num_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_obs(input logic [3:0] m, input logic [3:0] v, input int lim);
        int n;
        n = 0;
        while ((obs & m) !== v && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        if ((obs & m) !== v)
            num_errors++;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic done(input string s);
        $display("test %s finished, mismatches so far %0d", s, num_errors);
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // free-running 250 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // watchdog far beyond the few hundred cycles the tests need
    initial
    begin
        #(4 * 20000);
        num_errors++;
        results();
    end

    // main sequence: reset, advertisement rows, then hand-written cases
    initial
    begin
        int n;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        adv_low = 1'b0;
        adv_mid = 1'b0;
        vbus = 1'b0;
        plugged = 1'b0;
        flipped = 1'b0;
        settle = 8'h00;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(32'(obs[3:2]), 32'h0);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        check(rd, 32'h1);
        apb(1'b0, MASK_OFFSET, 32'h0);
        check(rd, 32'h0);
        done("reset");
        // each row sets the advertisement input and waits for the decoded level
        for (int i = 0; i < 4; i++)
        begin
            adv_low <= row_in[i][1];
            adv_mid <= row_in[i][0];
            @(posedge pclk);
            for (n = 0; n < 50 && cc_pullup.level !== row_lvl[i]; n++)
                @(posedge pclk);
            check(32'(cc_pullup.level), 32'(row_lvl[i]));
            check(32'(cc_pullup.current_ua), 32'(row_ua[i]));
            check(32'(cc_pullup.enable), 32'h1);
            apb(1'b0, STATUS_OFFSET, 32'h0);
            check(32'(rd[5:4]), 32'(row_lvl[i]));
        end
        done("advertisement rows");
        // switching the controller off drops the pull-ups, back on restores them
        apb(1'b1, CTRL_OFFSET, 32'h0);
        idle(1);
        check(32'(cc_pullup.enable), 32'h0);
        apb(1'b1, CTRL_OFFSET, 32'h1);
        idle(1);
        check(32'(cc_pullup.enable), 32'h1);
        done("enable");
        apb(1'b0, 12'h010, 32'h0);
        check(rd, 32'h0);
        check(32'(err), 32'h1);
        apb(1'b1, 12'h010, 32'hffff_ffff);
        check(32'(err), 32'h1);
        done("unmapped");
        // stale advertisement events cleared, attach and detach unmasked
        apb(1'b1, IRQ_OFFSET, 32'hf);
        apb(1'b1, MASK_OFFSET, 32'h3);
        idle(2);
        check(32'(irq), 32'h0);
        // a sink shorter than the debounce never attaches
        plugged <= 1'b1;
        idle(10);
        plugged <= 1'b0;
        idle(40);
        check(32'(obs[3:2]), 32'h0);
        done("short sink");
        // vbus still up: attach must wait for it to fall
        vbus <= 1'b1;
        idle(20);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        check(32'(rd[3]), 32'h1);
        settle <= 8'h1e;
        plugged <= 1'b1;
        idle(80);
        check(32'(obs[3:2]), 32'h0);
        vbus <= 1'b0;
        wait_obs(4'b1000, 4'b1000, 100);
        idle(2);
        check(32'(obs), 32'hf);
        check(32'({ind_o, orient_o}), 32'h0);
        apb(1'b0, IRQ_OFFSET, 32'h0);
        check(32'(rd[0]), 32'h1);
        apb(1'b1, IRQ_OFFSET, 32'h1);
        idle(2);
        check(32'(irq), 32'h0);
        done("vbus blocks attach");
        plugged <= 1'b0;
        wait_obs(4'b1000, 4'b0000, 20);
        idle(2);
        check(32'({obs[3:2], irq}), 32'h1);
        apb(1'b1, IRQ_OFFSET, 32'hf);
        done("detach cc1");
        // prompt sink on cc2: not attached before the debounce runs out
        settle <= 8'h00;
        flipped <= 1'b1;
        plugged <= 1'b1;
        // two sync flops, one filter flop, the window, then the output flop
        idle(ATT + 4);
        check(32'(active_mode), 32'h0);
        idle(1);
        check(32'(active_mode), 32'h1);
        wait_obs(4'b1000, 4'b1000, 40);
        idle(2);
        check(32'(obs[3:1]), 32'h6);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        check(32'(rd[2:0]), 32'h5);
        plugged <= 1'b0;
        wait_obs(4'b1000, 4'b0000, 20);
        idle(2);
        check(32'(obs[3:2]), 32'h0);
        done("attach cc2");
        results();
    end
endmodule
